// >>> sswb_bank.sv
// Purpose: live supply status registers and aggregated warning
// Assumes: inputs synchronous to core_clk; byte register read/write port
// Notes:   registered read data, one cycle after the read strobe
//
// Summary of operation
// - warning is OR of all limit results and active secondary warnings
// - secondary warnings count only when dual-function pin is digital input
// - reads return live values, nothing latched
// - over-low bits 0-4 are primary over flags of mid and high inputs
// - over-low bits 5-7 dual detector or mid 1-3 secondary over warning
// - over-high bit0 dual4 or mid4, bit1 dual5 or high warning
// - under-low bits 0-4 are primary under flags of mid and high inputs
// - under-low bits 5-7 dual detector or mid 1-3 secondary under warning
// - under-high bit0 dual4 or mid4, bit1 dual5 or high warning
// - limit-low holds eight channel limit results, sense setting one
// - limit-high bits 0-1 hold dual 4 and 5 limit results
// - level register bits 0-4 are conditioned dual-function levels
// - unusable upper bits are not to be relied on
`timescale 1ns/1ps
`default_nettype none
module sswb_bank #(
  parameter int unsigned MID_N  = sswb_pkg::MID_N,
  parameter int unsigned DUAL_N = sswb_pkg::DUAL_N
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset,
  // register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic              reg_read,
  input  wire logic              reg_write,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata,
  output logic                   reg_rvalid,
  output logic                   reg_hit,
  // primary detectors: mid inputs 1-4 then high input
  input  wire logic [4:0]        primary_over_flag,
  input  wire logic [4:0]        primary_under_flag,
  // secondary warnings: mid inputs 1-4 then high input
  input  wire logic [4:0]        secondary_over_warn,
  input  wire logic [4:0]        secondary_under_warn,
  // dual-function inputs 1-5
  input  wire logic [4:0]        dual_over_flag,
  input  wire logic [4:0]        dual_under_flag,
  input  wire logic [4:0]        dual_is_digital,
  input  wire logic [4:0]        conditioned_level,
  // adc limit results
  input  wire logic [7:0]        limit_sense1_result,
  input  wire logic [1:0]        limit_sense2_result,
  // to sequence_controller
  output logic                   sequence_controller_warning
);

  wire logic [4:0] sel_over;
  wire logic [4:0] sel_under;
  wire logic [4:0] warn_over;
  wire logic [4:0] warn_under;
  wire logic [7:0] ov_low;
  wire logic [7:0] uv_low;
  wire logic [7:0] next_rdata;
  wire logic       next_hit;
  wire logic       next_warning;

  genvar g;
  generate
    for (g = 0; g < DUAL_N; g++) begin : g_ch
      sswb_channel_select u_ov (
        .is_digital     (dual_is_digital[g]),
        .detector_flag  (dual_over_flag[g]),
        .secondary_flag (secondary_over_warn[g]),
        .status_bit     (sel_over[g]),
        .warn_bit       (warn_over[g])
      );
      sswb_channel_select u_uv (
        .is_digital     (dual_is_digital[g]),
        .detector_flag  (dual_under_flag[g]),
        .secondary_flag (secondary_under_warn[g]),
        .status_bit     (sel_under[g]),
        .warn_bit       (warn_under[g])
      );
    end
  endgenerate

  assign ov_low = {sel_over[2:0], primary_over_flag};
  assign uv_low = {sel_under[2:0], primary_under_flag};

  assign next_warning = (|limit_sense1_result) | (|limit_sense2_result)
                      | (|warn_over) | (|warn_under);

  sswb_read_mux u_mux (
    .addr     (reg_addr),
    .ov_low   (ov_low),
    .ov_high  (sel_over[4:3]),
    .uv_low   (uv_low),
    .uv_high  (sel_under[4:3]),
    .lim_low  (limit_sense1_result),
    .lim_high (limit_sense2_result),
    .levels   (conditioned_level),
    .data     (next_rdata),
    .hit      (next_hit)
  );

  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata   <= sswb_pkg::RESET_READ_DATA;
      reg_rvalid  <= 1'b0;
      reg_hit     <= 1'b0;
      sequence_controller_warning <= sswb_pkg::RESET_WARNING;
    end else begin
      reg_rvalid  <= reg_read;
      reg_hit     <= reg_read & next_hit;
      sequence_controller_warning <= next_warning;
      if (reg_read) begin
        reg_rdata <= next_rdata;
      end
    end
  end

endmodule : sswb_bank
`default_nettype wire

// >>> sswb_pkg.sv
// Purpose: constants for the supply status and warning bank
// Assumes: byte-wide register port, 8-bit addresses
// Notes:   offsets are byte addresses on the management bus
package sswb_pkg;

  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned MID_N    = 4;
  localparam int unsigned DUAL_N   = 5;

  localparam logic [7:0] OFS_OVERVOLTAGE_FLAGS_LOW   = 8'hE2;
  localparam logic [7:0] OFS_OVERVOLTAGE_FLAGS_HIGH  = 8'hE3;
  localparam logic [7:0] OFS_UNDERVOLTAGE_FLAGS_LOW  = 8'hE4;
  localparam logic [7:0] OFS_UNDERVOLTAGE_FLAGS_HIGH = 8'hE5;
  localparam logic [7:0] OFS_ADC_LIMIT_FLAGS_LOW     = 8'hE6;
  localparam logic [7:0] OFS_ADC_LIMIT_FLAGS_HIGH    = 8'hE7;
  localparam logic [7:0] OFS_INPUT_LEVEL_FLAGS       = 8'hE8;

  localparam logic [7:0] RESET_READ_DATA = 8'h00;
  localparam logic       RESET_WARNING   = 1'b0;

  localparam int unsigned POS_PRIMARY_LSB = 0;
  localparam int unsigned POS_DUAL_LSB    = 5;

endpackage : sswb_pkg

// >>> sswb_channel_select.sv
// Purpose: picks detector result or secondary warning for one dual-function channel
// Assumes: inputs synchronous to core_clk
// Notes:   secondary warning only counts while the pin is a digital input
`timescale 1ns/1ps
`default_nettype none
module sswb_channel_select (
  // mode
  input  wire logic is_digital,
  // sources
  input  wire logic detector_flag,
  input  wire logic secondary_flag,
  // results
  output wire logic status_bit,
  output wire logic warn_bit
);
  assign warn_bit   = is_digital & secondary_flag;
  assign status_bit = is_digital ? secondary_flag : detector_flag;
endmodule : sswb_channel_select
`default_nettype wire

// >>> sswb_read_mux.sv
// Purpose: read data decode for the status registers
// Assumes: one byte register per address
// Notes:   unmapped and reserved bits read zero
`timescale 1ns/1ps
`default_nettype none
module sswb_read_mux (
  // address
  input  wire logic [7:0] addr,
  // register images
  input  wire logic [7:0] ov_low,
  input  wire logic [1:0] ov_high,
  input  wire logic [7:0] uv_low,
  input  wire logic [1:0] uv_high,
  input  wire logic [7:0] lim_low,
  input  wire logic [1:0] lim_high,
  input  wire logic [4:0] levels,
  // result
  output logic      [7:0] data,
  output logic            hit
);
  always_comb begin
    hit  = 1'b1;
    data = sswb_pkg::RESET_READ_DATA;
    case (addr)
      sswb_pkg::OFS_OVERVOLTAGE_FLAGS_LOW:   data = ov_low;
      sswb_pkg::OFS_OVERVOLTAGE_FLAGS_HIGH:  data = {6'h00, ov_high};
      sswb_pkg::OFS_UNDERVOLTAGE_FLAGS_LOW:  data = uv_low;
      sswb_pkg::OFS_UNDERVOLTAGE_FLAGS_HIGH: data = {6'h00, uv_high};
      sswb_pkg::OFS_ADC_LIMIT_FLAGS_LOW:     data = lim_low;
      sswb_pkg::OFS_ADC_LIMIT_FLAGS_HIGH:    data = {6'h00, lim_high};
      sswb_pkg::OFS_INPUT_LEVEL_FLAGS:       data = {3'h0, levels};
      default:                               hit  = 1'b0;
    endcase
  end
endmodule : sswb_read_mux
`default_nettype wire

// >>> sswb_bank_monitor.sv
// Purpose: read and warning timing checks
// Assumes: reads one cycle, warning registered
// Notes:   bound to sswb_bank
`timescale 1ns/1ps
`default_nettype none
module sswb_bank_monitor (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic       reg_hit,
  // sources and warning
  input wire logic [4:0] primary_over_flag,
  input wire logic [7:0] limit_sense1_result,
  input wire logic [1:0] limit_sense2_result,
  input wire logic       sequence_controller_warning
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  wire mapped = reg_addr inside {[8'hE2:8'hE8]};
  property p_rv; reg_read |=> reg_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("no valid after read");
  property p_quiet; !reg_read |=> !reg_rvalid; endproperty
  a_quiet: assert property (p_quiet) else $error("valid without read");
  property p_hit; reg_read && mapped |=> reg_hit; endproperty
  a_hit: assert property (p_hit) else $error("mapped read missed");
  property p_miss; reg_read && !mapped |=> !reg_hit && reg_rdata == 8'h00; endproperty
  a_miss: assert property (p_miss) else $error("unmapped read");
  property p_ov; reg_read && reg_addr == 8'hE2 |=> reg_rdata[4:0] == $past(primary_over_flag);
  endproperty
  a_ov: assert property (p_ov) else $error("over flags wrong");
  property p_l1; reg_read && reg_addr == 8'hE6 |=> reg_rdata == $past(limit_sense1_result);
  endproperty
  a_l1: assert property (p_l1) else $error("limit low wrong");
  property p_l2;
    reg_read && reg_addr == 8'hE7 |=> reg_rdata == {6'h00, $past(limit_sense2_result)};
  endproperty
  a_l2: assert property (p_l2) else $error("limit high wrong");
  property p_warn; |{limit_sense1_result, limit_sense2_result} |=> sequence_controller_warning;
  endproperty
  a_warn: assert property (p_warn) else $error("warning missing");
endmodule : sswb_bank_monitor
bind sswb_bank sswb_bank_monitor u_sswb_bank_monitor (.core_clk(core_clk), .reset(reset),
  .reg_addr(reg_addr), .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .reg_hit(reg_hit), .primary_over_flag(primary_over_flag),
  .limit_sense1_result(limit_sense1_result), .limit_sense2_result(limit_sense2_result),
  .sequence_controller_warning(sequence_controller_warning));
`default_nettype wire

// >>> sswb_bank_tb_top.sv
// Purpose: directed reads of the status bank
// Assumes: read data one cycle after strobe
// Notes:   inputs change at falling edge
`timescale 1ns/1ps
`default_nettype none
module sswb_bank_tb_top;
  logic       core_clk = 0, reset = 1, rd = 0, wr = 0;
  logic [7:0] ad = 0, wd = 0, l1 = 0;
  logic [4:0] po = 0, pu = 0, so = 0, su = 0, dov = 0, du = 0, dg = 0, lv = 0;
  logic [1:0] l2 = 0;
  wire  [7:0] rdat;
  wire        rv, hit, warn;
  int         n_errors = 0, n_compared = 0, cyc = 0;
  logic [7:0] ex [9] = '{8'h00, 8'hF5, 8'h01, 8'h4A, 8'h03, 8'h00, 8'h00, 8'h13, 8'h00};
  sswb_bank u_sswb_bank (.core_clk(core_clk), .reset(reset), .reg_addr(ad), .reg_read(rd),
    .reg_write(wr), .reg_wdata(wd), .reg_rdata(rdat), .reg_rvalid(rv), .reg_hit(hit),
    .primary_over_flag(po), .primary_under_flag(pu), .secondary_over_warn(so),
    .secondary_under_warn(su), .dual_over_flag(dov), .dual_under_flag(du),
    .dual_is_digital(dg), .conditioned_level(lv), .limit_sense1_result(l1),
    .limit_sense2_result(l2), .sequence_controller_warning(warn));
  initial forever #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 2000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(negedge core_clk);
    ad = a;
    rd = 1'b1;
    @(negedge core_clk);
    rd = 1'b0;
    chk({7'h00, rv}, 8'h01);
    chk({7'h00, hit}, {7'h00, (a inside {[8'hE2:8'hE8]})});
    chk(rdat, exp);
  endtask : rdc
  task automatic wrap_up();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (10) @(negedge core_clk);
    reset = 1'b0;
    chk({rdat[7:1], warn}, 8'h00);
    po = 5'h15; so = 5'h1F; dov = 5'h0A; dg = 5'h05; pu = 5'h0A; du = 5'h1F; lv = 5'h13;
    foreach (ex[i]) rdc(8'(8'hE1 + i), ex[i]);
    chk({7'h00, warn}, 8'h01);
    dg = 5'h00;
    @(negedge core_clk);
    chk({7'h00, warn}, 8'h00);
    l2 = 2'b10;
    rdc(8'hE7, 8'h02);
    chk({7'h00, warn}, 8'h01);
    l2 = 2'b00;
    l1 = 8'h80;
    po = 5'h0E;
    rdc(8'hE6, 8'h80);
    chk({7'h00, warn}, 8'h01);
    rdc(8'hE2, 8'h4E);
    rdc(8'hE3, 8'h01);
    rdc(8'hE4, 8'hEA);
    ad = 8'hE2;
    wd = 8'hFF;
    wr = 1'b1;
    @(negedge core_clk);
    wr = 1'b0;
    rdc(8'hE2, 8'h4E);
    // under-side secondary warning alone
    l1 = 8'h00;
    so = 5'h00;
    su = 5'h10;
    dg = 5'h10;
    rdc(8'hE5, 8'h03);
    chk({7'h00, warn}, 8'h01);
    rdc(8'hE3, 8'h01);
    // mid-run reset clears read data and warning
    reset = 1'b1;
    repeat (2) @(negedge core_clk);
    chk(rdat, 8'h00);
    chk({6'h00, rv, warn}, 8'h00);
    reset = 1'b0;
    rdc(8'hE8, 8'h13);
    chk({7'h00, warn}, 8'h01);
    wrap_up();
  end
endmodule : sswb_bank_tb_top
`default_nettype wire
